// file: rtl/amlc_bitord.sv
// bit order reversal for mirror-image characters
`timescale 1ns/10ps
module amlc_bitord #(
	parameter int W = 8
) (
	// control
	input  wire logic         mirror,
	// data
	input  wire logic [W-1:0] data_in,
	output logic      [W-1:0] data_out
);
	always_comb begin
		for (int k = 0; k < W; k++) begin
			data_out[k] = mirror ? data_in[W-1-k] : data_in[k];
		end
	end
endmodule

// file: rtl/amlc_chg_det.sv
// control-line-in change detector, quiet on the activating cycle
`timescale 1ns/10ps
module amlc_chg_det (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rst_n,
	// carrier
	amlc_chg_if.det   chg_if
);
	typedef struct packed {
		logic [3:0] prev;
		logic [3:0] armed;
		logic [3:0] change;
	} amlc_det_type;

	amlc_det_type state_ff;
	amlc_det_type nxt_state;

	// a line only counts edges after a full cycle of being active, so the
	// level present when it is activated never reports
	always_comb begin
		nxt_state        = state_ff;
		nxt_state.prev   = chg_if.level;
		nxt_state.armed  = chg_if.arm;
		nxt_state.change = chg_if.arm & state_ff.armed & (chg_if.level ^ state_ff.prev);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign chg_if.change = state_ff.change;
endmodule

// file: rtl/amlc_chg_if.sv
// change-detect carrier between the adapter and its edge detector
`timescale 1ns/10ps
interface amlc_chg_if;
	logic [3:0] level;
	logic [3:0] arm;
	logic [3:0] change;

	modport src (output level, output arm, input change);
	modport det (input level, input arm, output change);
endinterface

// file: rtl/amlc_line_adapter.sv
// four-line async modem line adapter: setup, status, requests, modem control
//
// Functional notes
// - line error type in bits 7:6: 00 framing, 01 parity, 10 overflow, 11 both
// - status byte: interlock, carrier, cts, zero, zero, ring, control-in, underflow
// - underflow bit when buffer and register empty; requests status if interrupt bit
// - control-in change requests status while active, never on activation
// - ring bit mirrors ring; requests status only with accept-ring and no transmit
// - cts, carrier, interlock mirror modem, never request; unused bits zero
// - setup command, control interrupt when free, setup word loads addressed line
// - setup word: payload 15-8, selector 7-6, address 5-0; 00 data, 01 control
// - normal mode sends word bit 8 first, short characters right justified
// - mirror mode sends word bit 15 first, short characters left justified
// - transmit raises rts, output requests once cts, breaks reported with carrier
// - receive enables input requests and error reports once carrier present
// - echo keeps rts, suppresses output requests, retransmits received characters
// - terminal-ready bit drives modem data-terminal-ready
// - accept-ring requests status on ring without transmit; sends breaks with transmit
// - control-line bit drives outgoing control line to modem
// - interrupt bit requests status on empty; host clears it afterwards
// - transmit cleared by reload keeps rts until output register drains
// - speed bit selects rate B; host leaves it alone while line active
// - read command, control interrupt, select word picks data or status reply
// - reply: selected byte 15-8, zeros at 7-6, line address 5-0
`timescale 1ns/10ps
module amlc_line_adapter (
	// clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    rst_n,
	// straps
	input  wire logic [3:0]              line_adapter_base,
	input  wire logic                    mirror_mode,
	input  wire logic                    echo_disable,
	// command and word exchange with the scan unit
	input  wire logic                    cmd_stb,
	input  wire logic                    cmd_read,
	output logic                         ctl_irq,
	input  wire logic                    word_stb,
	input  wire amlc_pkg::amlc_word_type word_in,
	output amlc_pkg::amlc_word_type      reply_word,
	output logic                         reply_valid,
	// service requests to the scan unit
	output amlc_pkg::amlc_lines_type     odr,
	output amlc_pkg::amlc_lines_type     idr,
	output amlc_pkg::amlc_lines_type     sir,
	output amlc_pkg::amlc_lines_type     lerr,
	output amlc_pkg::amlc_errs_type      lerr_type,
	// receiver/transmitter chips
	input  wire amlc_pkg::amlc_lines_type tx_buf_empty,
	input  wire amlc_pkg::amlc_lines_type tx_reg_empty,
	output amlc_pkg::amlc_lines_type     tx_load,
	output amlc_pkg::amlc_bytes_type     tx_data,
	input  wire amlc_pkg::amlc_lines_type rx_ready,
	input  wire amlc_pkg::amlc_bytes_type rx_data,
	input  wire amlc_pkg::amlc_lines_type rx_frame_err,
	input  wire amlc_pkg::amlc_lines_type rx_par_err,
	input  wire amlc_pkg::amlc_lines_type rx_ovr_err,
	output amlc_pkg::amlc_lines_type     rx_taken,
	output amlc_pkg::amlc_lines_type     send_break,
	output amlc_pkg::amlc_lines_type     speed_b,
	// modem lines
	input  wire amlc_pkg::amlc_lines_type modem_cts,
	input  wire amlc_pkg::amlc_lines_type modem_carrier,
	input  wire amlc_pkg::amlc_lines_type modem_interlock,
	input  wire amlc_pkg::amlc_lines_type modem_ring,
	input  wire amlc_pkg::amlc_lines_type modem_ctl_in,
	output amlc_pkg::amlc_lines_type     modem_rts,
	output amlc_pkg::amlc_lines_type     modem_dtr,
	output amlc_pkg::amlc_lines_type     modem_ctl_out
);
	import amlc_pkg::*;

	typedef struct packed {
		amlc_seq_type   seq;
		logic           rd_cmd;
		logic           ctl_irq;
		amlc_word_type  rep_word;
		logic           rep_valid;
		amlc_bytes_type ctl;
		amlc_lines_type hold;
		amlc_lines_type sir;
		amlc_lines_type idr;
		amlc_lines_type lerr;
		amlc_errs_type  err_type;
		amlc_bytes_type rx_byte;
		amlc_lines_type odr;
		amlc_lines_type tx_load;
		amlc_bytes_type tx_data;
		amlc_lines_type rx_taken;
		amlc_lines_type rts;
		amlc_lines_type dtr;
		amlc_lines_type ctl_out;
		amlc_lines_type speed_b;
		amlc_lines_type brk;
	} amlc_state_type;

	amlc_state_type state_ff;
	amlc_state_type nxt_state;

	amlc_chg_if     chg_bus ();
	amlc_byte_type  tx_ordered;
	amlc_bytes_type rx_ordered;
	amlc_bytes_type stat_byte;

	logic [1:0]     word_sel;
	logic [1:0]     word_line;
	logic           word_hit;
	logic           word_take;

	assign word_sel  = word_in[WD_SEL_HI:WD_SEL_LO];
	assign word_line = word_in[WD_ADR_LO+1:WD_ADR_LO];
	assign word_hit  = (word_in[WD_ADR_HI:WD_ADR_LO+2] == line_adapter_base);
	assign word_take = word_stb && (state_ff.seq == ST_WORD) && word_hit;

	// payload reordering toward the chip, which always shifts its bit 0 first
	amlc_bitord #(
		.W        (8)
	) u_tx_ord (
		.mirror   (mirror_mode),
		.data_in  (word_in[WD_PAY_HI:WD_PAY_LO]),
		.data_out (tx_ordered)
	);

	for (genvar g = 0; g < NLINES; g++) begin : g_line
		amlc_bitord #(
			.W        (8)
		) u_rx_ord (
			.mirror   (mirror_mode),
			.data_in  (rx_data[g]),
			.data_out (rx_ordered[g])
		);

		always_comb begin
			stat_byte[g]          = 8'h00;
			stat_byte[g][SB_ILK]  = modem_interlock[g];
			stat_byte[g][SB_CARR] = modem_carrier[g];
			stat_byte[g][SB_CTS]  = modem_cts[g];
			stat_byte[g][SB_RING] = modem_ring[g];
			stat_byte[g][SB_CLIN] = modem_ctl_in[g];
			stat_byte[g][SB_UNDR] = tx_buf_empty[g] & tx_reg_empty[g];
		end

		assign chg_bus.level[g] = modem_ctl_in[g];
		assign chg_bus.arm[g]   = state_ff.ctl[g][CB_XMIT] | state_ff.ctl[g][CB_RECV];
	end

	amlc_chg_det u_chg (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.chg_if  (chg_bus)
	);

	always_comb begin
		logic           xmit;
		logic           echo;
		logic           rx_ok;
		logic           set_sir;
		logic           clr_sir;
		logic           clr_rx;
		logic [1:0]     etype;
		xmit    = 1'b0;
		echo    = 1'b0;
		rx_ok   = 1'b0;
		set_sir = 1'b0;
		clr_sir = 1'b0;
		clr_rx  = 1'b0;
		etype   = ERR_FRAME;

		nxt_state           = state_ff;
		nxt_state.ctl_irq   = 1'b0;
		nxt_state.rep_valid = 1'b0;
		nxt_state.tx_load   = '0;
		nxt_state.rx_taken  = '0;

		// command sequencing: interrupt once free, then one word
		case (state_ff.seq)
			ST_IDLE: begin
				if (cmd_stb) begin
					nxt_state.ctl_irq = 1'b1;
					nxt_state.rd_cmd  = cmd_read;
					nxt_state.seq     = ST_WORD;
				end
			end
			ST_WORD: begin
				if (word_stb) begin
					nxt_state.seq = ST_IDLE;
				end
				if (word_take && state_ff.rd_cmd) begin
					nxt_state.rep_valid = 1'b1;
					nxt_state.rep_word  = {((word_sel == SEL_STAT) ? stat_byte[word_line]
						: state_ff.rx_byte[word_line]), 2'b00, word_in[WD_ADR_HI:WD_ADR_LO]};
				end
			end
			default: begin
				nxt_state.seq = ST_IDLE;
			end
		endcase

		for (int l = 0; l < NLINES; l++) begin
			// setup word for this line
			if (word_take && !state_ff.rd_cmd && (word_line == 2'(l))) begin
				if (word_sel == SEL_DATA) begin
					nxt_state.tx_load[l] = 1'b1;
					nxt_state.tx_data[l] = tx_ordered;
				end else if (word_sel == SEL_CTRL) begin
					nxt_state.ctl[l] = word_in[WD_PAY_HI:WD_PAY_LO];
					// transmit dropped with a character still shifting
					if (state_ff.ctl[l][CB_XMIT] && !word_in[WD_PAY_LO + CB_XMIT]
							&& !tx_reg_empty[l]) begin
						nxt_state.hold[l] = 1'b1;
					end
				end
			end
			if (tx_reg_empty[l]) begin
				nxt_state.hold[l] = 1'b0;
			end

			xmit  = state_ff.ctl[l][CB_XMIT];
			echo  = state_ff.ctl[l][CB_ECHO];
			rx_ok = rx_ready[l] && state_ff.ctl[l][CB_RECV] && modem_carrier[l];

			// received character: capture, request, error report, echo
			if (rx_ok) begin
				nxt_state.rx_taken[l] = 1'b1;
				nxt_state.rx_byte[l]  = rx_ordered[l];
				nxt_state.idr[l]      = 1'b1;
				if (rx_par_err[l] || rx_ovr_err[l]) begin
					etype = {rx_ovr_err[l], rx_par_err[l]};
				end else begin
					etype = ERR_FRAME;
				end
				// breaks show up as framing errors and only with carrier
				if (rx_frame_err[l] || rx_par_err[l] || rx_ovr_err[l]) begin
					nxt_state.lerr[l]     = 1'b1;
					nxt_state.err_type[l] = etype;
				end
				// echo shares the chip path; a host data load the same cycle wins
				if (echo && !echo_disable && !nxt_state.tx_load[l]) begin
					nxt_state.tx_load[l] = 1'b1;
					nxt_state.tx_data[l] = rx_data[l];
				end
			end

			// data read clears input request and error; a new one wins
			clr_rx = word_take && state_ff.rd_cmd && (word_sel == SEL_DATA)
				&& (word_line == 2'(l));
			if (clr_rx && !rx_ok) begin
				nxt_state.idr[l]  = 1'b0;
				nxt_state.lerr[l] = 1'b0;
			end

			// status-change requests
			set_sir = (state_ff.ctl[l][CB_UNDR] && tx_buf_empty[l] && tx_reg_empty[l])
				|| (state_ff.ctl[l][CB_RING] && !xmit && modem_ring[l])
				|| chg_bus.change[l];
			clr_sir = word_take && state_ff.rd_cmd && (word_sel == SEL_STAT)
				&& (word_line == 2'(l));
			nxt_state.sir[l] = (state_ff.sir[l] && !clr_sir) || set_sir;

			// output data request, held off while echo owns the transmitter
			nxt_state.odr[l] = xmit && !echo && modem_cts[l] && tx_buf_empty[l]
				&& !nxt_state.tx_load[l];

			// modem and chip controls follow the control byte now in force
			nxt_state.rts[l]     = nxt_state.ctl[l][CB_XMIT] | nxt_state.ctl[l][CB_ECHO]
				| nxt_state.hold[l];
			nxt_state.dtr[l]     = nxt_state.ctl[l][CB_TRDY];
			nxt_state.ctl_out[l] = nxt_state.ctl[l][CB_CLINE];
			nxt_state.speed_b[l] = nxt_state.ctl[l][CB_SPEED];
			nxt_state.brk[l]     = nxt_state.ctl[l][CB_XMIT] & nxt_state.ctl[l][CB_RING];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff          <= '0;
			state_ff.seq      <= ST_IDLE;
			state_ff.rep_word <= REP_RST;
			state_ff.ctl      <= {NLINES{CTL_RST}};
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign ctl_irq       = state_ff.ctl_irq;
	assign reply_word    = state_ff.rep_word;
	assign reply_valid   = state_ff.rep_valid;
	assign odr           = state_ff.odr;
	assign idr           = state_ff.idr;
	assign sir           = state_ff.sir;
	assign lerr          = state_ff.lerr;
	assign lerr_type     = state_ff.err_type;
	assign tx_load       = state_ff.tx_load;
	assign tx_data       = state_ff.tx_data;
	assign rx_taken      = state_ff.rx_taken;
	assign send_break    = state_ff.brk;
	assign speed_b       = state_ff.speed_b;
	assign modem_rts     = state_ff.rts;
	assign modem_dtr     = state_ff.dtr;
	assign modem_ctl_out = state_ff.ctl_out;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_err_type_code: assert property (
		(rx_ready[0] && state_ff.ctl[0][CB_RECV] && modem_carrier[0] && rx_par_err[0]
			&& rx_ovr_err[0]) |=> (lerr[0] && lerr_type[0] == ERR_BOTH))
		else $error("line error type not parity plus overflow");

	a_status_layout: assert property (
		(word_take && state_ff.rd_cmd && word_sel == SEL_STAT)
			|=> (reply_word[12:11] == 2'b00 && reply_word[15] == $past(modem_interlock[word_line])))
		else $error("status byte layout wrong");

	a_under_sir: assert property (
		(state_ff.ctl[2][CB_UNDR] && tx_buf_empty[2] && tx_reg_empty[2]) |=> sir[2])
		else $error("underflow did not raise status request");

	a_ring_gate: assert property (
		(modem_ring[1] && state_ff.ctl[1][CB_RING] && !state_ff.ctl[1][CB_XMIT]) |=> sir[1])
		else $error("ring did not raise status request");

	a_ctl_irq_once: assert property (
		(state_ff.seq == ST_IDLE && cmd_stb) |=> ctl_irq ##1 !ctl_irq)
		else $error("control interrupt not a single pulse");

	a_echo_no_odr: assert property (
		state_ff.ctl[0][CB_ECHO] |=> !odr[0])
		else $error("output request during echo");

	a_rts_hold: assert property (
		(state_ff.hold[0] && !tx_reg_empty[0]) |=> modem_rts[0])
		else $error("rts dropped before register drained");

	a_dtr_follow: assert property (
		$rose(state_ff.ctl[1][CB_TRDY]) |=> modem_dtr[1])
		else $error("dtr does not follow control byte");

	a_reply_addr: assert property (
		(word_take && state_ff.rd_cmd) |=> (reply_valid && reply_word[5:0] == $past(word_in[5:0])
			&& reply_word[7:6] == 2'b00))
		else $error("reply address or zero bits wrong");

	c_setup_ctrl: cover property (word_take && !state_ff.rd_cmd && word_sel == SEL_CTRL);
	c_status_read: cover property (word_take && state_ff.rd_cmd && word_sel == SEL_STAT);
	c_echo_load: cover property (tx_load[0] && state_ff.ctl[0][CB_ECHO]);
	c_line_error: cover property ($rose(lerr[0]));
endmodule

// file: rtl/amlc_pkg.sv
// shared constants and types of the four-line async modem line adapter
package amlc_pkg;
	localparam int NLINES = 4;

	typedef logic [3:0]       amlc_lines_type;
	typedef logic [3:0][7:0]  amlc_bytes_type;
	typedef logic [3:0][1:0]  amlc_errs_type;
	typedef logic [15:0]      amlc_word_type;
	typedef logic [7:0]       amlc_byte_type;

	// setup / select / reply word fields
	localparam int WD_PAY_HI = 15;
	localparam int WD_PAY_LO = 8;
	localparam int WD_SEL_HI = 7;
	localparam int WD_SEL_LO = 6;
	localparam int WD_ADR_HI = 5;
	localparam int WD_ADR_LO = 0;

	localparam logic [1:0] SEL_DATA = 2'h0;
	localparam logic [1:0] SEL_CTRL = 2'h1;
	localparam logic [1:0] SEL_STAT = 2'h1;

	// control byte bit positions
	localparam int CB_XMIT  = 7;
	localparam int CB_RECV  = 6;
	localparam int CB_ECHO  = 5;
	localparam int CB_TRDY  = 4;
	localparam int CB_RING  = 3;
	localparam int CB_CLINE = 2;
	localparam int CB_UNDR  = 1;
	localparam int CB_SPEED = 0;

	// status byte bit positions (bits 4 and 3 unused, read zero)
	localparam int SB_ILK  = 7;
	localparam int SB_CARR = 6;
	localparam int SB_CTS  = 5;
	localparam int SB_RING = 2;
	localparam int SB_CLIN = 1;
	localparam int SB_UNDR = 0;

	// line error type codes, carried as {a,b} in word bits 7:6
	localparam logic [1:0] ERR_FRAME = 2'h0;
	localparam logic [1:0] ERR_PAR   = 2'h1;
	localparam logic [1:0] ERR_OVF   = 2'h2;
	localparam logic [1:0] ERR_BOTH  = 2'h3;

	localparam logic [7:0]  CTL_RST = 8'h00;
	localparam logic [15:0] REP_RST = 16'h0000;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WORD = 2'b10
	} amlc_seq_type;
endpackage

// file: verification/amlc_scan_model.sv
// scan unit model: issues commands and words to the line adapter
`timescale 1ns/10ps
module amlc_scan_model (
	// clock
	input  wire logic                    ref_clk,
	// command and word exchange
	output logic                         cmd_stb,
	output logic                         cmd_read,
	input  wire logic                    ctl_irq,
	output logic                         word_stb,
	output amlc_pkg::amlc_word_type      word_in,
	// count of interrupts that never came
	output int                           irq_miss
);
	import amlc_pkg::*;

	initial begin
		cmd_stb  = 1'b0;
		cmd_read = 1'b0;
		word_stb = 1'b0;
		word_in  = 16'hffff;
		irq_miss = 0;
	end

	// gap lets the host answer the interrupt late
	task automatic xfer(input logic rd, input amlc_word_type w, input int gap);
		int n;
		n = 0;
		@(posedge ref_clk) #1;
		cmd_stb  = 1'b1;
		cmd_read = rd;
		@(posedge ref_clk) #1;
		cmd_stb = 1'b0;
		while (ctl_irq !== 1'b1 && n < 8) begin
			@(posedge ref_clk) #1;
			n++;
		end
		if (n == 8)
			irq_miss++;
		repeat (gap) @(posedge ref_clk) #1;
		word_stb = 1'b1;
		word_in  = w;
		@(posedge ref_clk) #1;
		word_stb = 1'b0;
		// stale word is not left on the bus
		word_in  = ~w;
		cmd_read = ~rd;
	endtask
endmodule

// file: verification/testbench.sv
// self-checking bench of the four-line modem line adapter
`timescale 1ns/10ps
module testbench;
	import amlc_pkg::*;
	logic           ref_clk, rst_n, mirror_mode, echo_disable;
	logic           cmd_stb, cmd_read, ctl_irq, word_stb, reply_valid;
	logic [3:0]     line_adapter_base;
	amlc_word_type  word_in, reply_word;
	amlc_lines_type odr, idr, sir, lerr, tx_load, rx_taken, send_break, speed_b;
	amlc_lines_type modem_rts, modem_dtr, modem_ctl_out, tx_buf_empty, tx_reg_empty;
	amlc_lines_type rx_ready, rx_frame_err, rx_par_err, rx_ovr_err, modem_cts;
	amlc_lines_type modem_carrier, modem_interlock, modem_ring, modem_ctl_in;
	amlc_errs_type  lerr_type;
	amlc_bytes_type tx_data, rx_data;
	amlc_byte_type  ctl [4];
	logic [15:0]    q_rep [$];
	logic [9:0]     q_tx [$];
	logic [7:0]     b, r;
	int             fail_count, compares, irq_miss, seed;

	amlc_line_adapter u_dut (.ref_clk, .rst_n, .line_adapter_base, .mirror_mode, .echo_disable,
		.cmd_stb, .cmd_read, .ctl_irq, .word_stb, .word_in, .reply_word, .reply_valid, .odr,
		.idr, .sir, .lerr, .lerr_type, .tx_buf_empty, .tx_reg_empty, .tx_load, .tx_data,
		.rx_ready, .rx_data, .rx_frame_err, .rx_par_err, .rx_ovr_err, .rx_taken, .send_break,
		.speed_b, .modem_cts, .modem_carrier, .modem_interlock, .modem_ring, .modem_ctl_in,
		.modem_rts, .modem_dtr, .modem_ctl_out);
	amlc_scan_model u_mux (.ref_clk, .cmd_stb, .cmd_read, .ctl_irq, .word_stb, .word_in,
		.irq_miss);

	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic end_of_test;
		if (fail_count == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk) #1;
	endtask

	// a read notes the reply it should bring before the command goes out
	task automatic xw(input logic rd, input logic [1:0] sel, input logic [1:0] l,
			input logic [7:0] p, input logic [7:0] e = 8'h00);
		if (rd)
			q_rep.push_back({e, 2'b00, line_adapter_base, l});
		u_mux.xfer(rd, {p, sel, line_adapter_base, l}, $random(seed) & 1);
	endtask

	task automatic wc(input int l, input logic [7:0] v);
		ctl[l] = v;
		xw(1'b0, SEL_CTRL, 2'(l), v);
		tick(1);
	endtask

	function automatic logic [7:0] stat(input int l);
		return {modem_interlock[l], modem_carrier[l], modem_cts[l], 2'b00, modem_ring[l],
			modem_ctl_in[l], tx_buf_empty[l] & tx_reg_empty[l]};
	endfunction

	// valid only while no output register is busy, else rts may be held
	task automatic chk_ctl;
		logic [4:0][3:0] v;
		for (int i = 0; i < 4; i++) begin
			v[0][i] = ctl[i][CB_TRDY];
			v[1][i] = ctl[i][CB_CLINE];
			v[2][i] = ctl[i][CB_SPEED];
			v[3][i] = ctl[i][CB_XMIT] | ctl[i][CB_ECHO];
			v[4][i] = ctl[i][CB_XMIT] & ctl[i][CB_RING];
		end
		cmp("modem_dtr", 16'(v[0]), 16'(modem_dtr));
		cmp("modem_ctl_out", 16'(v[1]), 16'(modem_ctl_out));
		cmp("speed_b", 16'(v[2]), 16'(speed_b));
		cmp("modem_rts", 16'(v[3]), 16'(modem_rts));
		cmp("send_break", 16'(v[4]), 16'(send_break));
	endtask

	// chip holds its data register after the character, as the real part does
	task automatic rx(input int l, input logic [2:0] f, input logic [7:0] d);
		rx_data[l] = d;
		{rx_frame_err[l], rx_par_err[l], rx_ovr_err[l]} = f;
		rx_ready[l] = 1'b1;
		tick(1);
		cmp("rx_taken", 16'({15'h0000, ctl[l][CB_RECV] & modem_carrier[l]} << l),
			16'(rx_taken));
		rx_ready[l] = 1'b0;
		tick(1);
	endtask

	always @(posedge ref_clk) begin
		if (reply_valid === 1'b1)
			cmp("reply_word", q_rep.size() ? q_rep.pop_front() : 16'hxxxx, reply_word);
		for (int i = 0; i < 4; i++)
			if (tx_load[i] === 1'b1)
				cmp("tx_data", q_tx.size() ? q_tx.pop_front() : 10'hxxx,
					16'({i[1:0], tx_data[i]}));
	end

	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	initial begin
		#(25 * 20000);
		fail_count++;
		end_of_test;
	end

	initial begin
		seed = 9192;
		fail_count = 0;
		compares = 0;
		rst_n = 1'b0;
		line_adapter_base = 4'h9;
		{mirror_mode, echo_disable} = 2'b00;
		{tx_buf_empty, tx_reg_empty} = 8'h0f;
		{rx_ready, rx_frame_err, rx_par_err, rx_ovr_err} = 16'h0000;
		rx_data = '0;
		{modem_cts, modem_carrier, modem_interlock, modem_ring, modem_ctl_in} = 20'h00000;
		ctl = '{default: 8'h00};
		repeat (5) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		repeat (2) begin
			for (int i = 0; i < 4; i++)
				wc(i, 8'($random(seed)));
			chk_ctl;
		end
		// foreign address and unused selector must change nothing
		u_mux.xfer(1'b0, {~ctl[0], SEL_CTRL, line_adapter_base ^ 4'h1, 2'b00}, 0);
		xw(1'b0, 2'b10, 2'd1, ~ctl[1]);
		tick(1);
		chk_ctl;
		for (int i = 0; i < 4; i++)
			wc(i, 8'h00);
		repeat (2) begin
			{modem_cts, modem_carrier, modem_interlock, modem_ring, modem_ctl_in} = 20'($random(seed));
			{tx_buf_empty, tx_reg_empty} = 8'($random(seed));
			for (int i = 0; i < 4; i++)
				xw(1'b1, SEL_STAT, 2'(i), 8'h00, stat(i));
			tick(2);
			cmp("sir", 16'h0, 16'(sir));
		end
		{modem_cts, modem_carrier, modem_interlock, modem_ring, modem_ctl_in} = 20'h00000;
		{tx_buf_empty, tx_reg_empty} = 8'h0f;
		modem_ring[1] = 1'b1;
		wc(1, 8'h88);
		tick(2);
		cmp("sir", 16'h0, 16'(sir));
		wc(1, 8'h08);
		tick(2);
		cmp("sir", 16'h2, 16'(sir));
		modem_ring[1] = 1'b0;
		wc(1, 8'h00);
		xw(1'b1, SEL_STAT, 2'd1, 8'h00, stat(1));
		wc(2, 8'h02);
		tick(2);
		cmp("sir", 16'h0, 16'(sir));
		tx_buf_empty[2] = 1'b1;
		tick(2);
		cmp("sir", 16'h4, 16'(sir));
		wc(2, 8'h00);
		xw(1'b1, SEL_STAT, 2'd2, 8'h00, stat(2));
		modem_ctl_in[3] = 1'b1;
		wc(3, 8'h40);
		tick(4);
		cmp("sir", 16'h0, 16'(sir));
		modem_ctl_in[3] = 1'b0;
		tick(3);
		cmp("sir", 16'h8, 16'(sir));
		wc(3, 8'h00);
		xw(1'b1, SEL_STAT, 2'd3, 8'h00, stat(3));
		wc(0, 8'h40);
		rx(0, 3'b000, 8'h5a);
		cmp("idr", 16'h0, 16'(idr));
		modem_carrier[0] = 1'b1;
		for (int k = 0; k < 4; k++) begin
			b = 8'($random(seed));
			rx(0, {k == 0, k[0], k[1]}, b);
			cmp("lerr_idr", 16'h11, 16'({lerr, idr}));
			cmp("lerr_type", 16'(k[1:0]), 16'(lerr_type[0]));
			xw(1'b1, SEL_DATA, 2'd0, 8'h00, b);
			tick(1);
			cmp("lerr_idr", 16'h0, 16'({lerr, idr}));
		end
		for (int m = 0; m < 2; m++) begin
			mirror_mode = m[0];
			b = 8'($random(seed));
			for (int j = 0; j < 8; j++)
				r[j] = b[7 - j];
			rx(0, 3'b000, b);
			xw(1'b1, SEL_DATA, 2'd0, 8'h00, m ? r : b);
			q_tx.push_back({2'd1, m ? r : b});
			xw(1'b0, SEL_DATA, 2'd1, b);
			tick(2);
		end
		mirror_mode = 1'b0;
		tx_buf_empty[0] = 1'b1;
		wc(0, 8'hc0);
		tick(2);
		cmp("odr", 16'h0, 16'(odr));
		modem_cts[0] = 1'b1;
		tick(2);
		cmp("odr", 16'h1, 16'(odr));
		wc(0, 8'he0);
		tick(2);
		cmp("odr", 16'h0, 16'(odr));
		chk_ctl;
		b = 8'($random(seed));
		q_tx.push_back({2'd0, b});
		rx(0, 3'b000, b);
		echo_disable = 1'b1;
		rx(0, 3'b000, ~b);
		tick(2);
		wc(0, 8'h80);
		tx_reg_empty[0] = 1'b0;
		wc(0, 8'h02);
		tick(3);
		cmp("modem_rts", 16'h1, 16'(modem_rts));
		cmp("sir", 16'h0, 16'(sir));
		tx_reg_empty[0] = 1'b1;
		tick(2);
		cmp("rts_sir", 16'h01, 16'({modem_rts, sir}));
		tick(4);
		cmp("irq_miss", 16'h0, 16'(irq_miss));
		cmp("queues", 16'h0, 16'(q_rep.size() + q_tx.size()));
		end_of_test;
	end
endmodule
